// ### src/io_interrupt_queue_and_block_dma.sv
// party-line interrupt queue and sixteen-channel block transfer processor
`timescale 1ns/100ps
`default_nettype none
// Operation
// - data level outranks service level; both share the party line
// - request with no higher level active issues a queue update
// - source id latched at update end; winner clears and releases
// - save counter at return location, jump through entry table
// - service level: own return location and entry table to FF
// - sixteen channels interleave; idle channels keep programmed i/o
// - channel n uses count 0x60+n and address 0x70+n
// - per word, address and negative count both increment
// - count reaching zero raises the data interrupt
// - chain flag 0: fetch next count then address after block
// - channels 0-3 hold words in registers loaded at initiate
// - register channel writes final address back before service
// - channels 4-15 read, update, write back memory every word
module io_interrupt_queue_and_block_dma
  import io_irq_dma_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [1:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [15:0]                   reg_rdata,
  input  wire logic                     data_req_line,
  input  wire logic                     serv_req_line,
  input  wire logic                     higher_level_active,
  input  wire logic [5:0]               src_id,
  output logic                          queue_update,
  output logic                          queue_is_serv,
  input  wire logic [15:0]              program_counter,
  input  wire logic [1:0]               level_exit,
  output io_irq_dma_pkg::jump_t         jump,
  output io_irq_dma_pkg::mem_req_t      mem_req,
  input  wire logic                     mem_ready,
  input  wire logic [15:0]              mem_rdata,
  input  wire logic [15:0]              dev_xfer_req,
  input  wire logic [15:0]              dev_rdata,
  output logic [15:0]                   dev_wdata,
  output logic [15:0]                   dev_xfer_ack,
  output logic [15:0]                   block_done,
  input  wire logic [15:0]              dev_finish,
  output logic [15:0]                   finish_ack
);
  import io_irq_dma_pkg::*;

  // lowest set bit, with a found flag on top
  function automatic logic [4:0] pick_lowest(input logic [15:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic is_reg_ch(input logic [3:0] c);
    return c[3:2] == 2'b00;
  endfunction

  // ****************************************
  // state
  // ****************************************
  fsm_t        state_q, state_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic [15:0] dir_q, dir_d, active_q, active_d, pend_q, pend_d;
  logic [15:0] seen_q, seen_d;
  logic [15:0] rtc_q [4];
  logic [15:0] rtc_d [4];
  logic [15:0] rta_q [4];
  logic [15:0] rta_d [4];
  logic [15:0] tc_q, tc_d, ta_q, ta_d;
  logic [3:0]  ch_q, ch_d;
  logic        init_q, init_d, lvl_q, lvl_d;
  logic [5:0]  src_q, src_d;
  logic [1:0]  busy_q, busy_d;
  logic [2:0]  qcnt_q, qcnt_d;
  logic [7:0]  pr_q, pr_d, pm_q, pm_d;
  logic [15:0] wd_q, wd_d, ack_q, ack_d, done_q, done_d, fack_q, fack_d;
  logic [15:0] rd_q, rd_d;
  jump_t       jump_q, jump_d;
  logic [15:0] xfer_elig;
  logic [4:0]  fin_pick, ld_pick, xf_pick;
  logic        data_go, serv_go;
  logic [CNT_W-1:0] cnt_inc;

  assign reg_rdata     = rd_q;
  assign jump          = jump_q;
  assign dev_wdata     = wd_q;
  assign dev_xfer_ack  = ack_q;
  assign block_done    = done_q;
  assign finish_ack    = fack_q;
  assign queue_update  = state_q == S_QUPD;
  assign queue_is_serv = lvl_q;

  // ****************************************
  // next-state logic
  // ****************************************
  // pacing is per class, not per channel: stricter, but needs two counters only
  always_comb begin
    state_d = state_q;
    ctrl_d  = ctrl_q;
    dir_d   = dir_q;
    active_d = active_q;
    pend_d  = pend_q;
    seen_d  = seen_q & dev_finish;
    rtc_d   = rtc_q;
    rta_d   = rta_q;
    tc_d    = tc_q;
    ta_d    = ta_q;
    ch_d    = ch_q;
    init_d  = init_q;
    lvl_d   = lvl_q;
    src_d   = src_q;
    busy_d  = busy_q & ~level_exit;
    qcnt_d  = qcnt_q;
    pr_d    = (pr_q != 8'h00) ? pr_q - 8'h01 : pr_q;
    pm_d    = (pm_q != 8'h00) ? pm_q - 8'h01 : pm_q;
    wd_d    = wd_q;
    ack_d   = '0;
    done_d  = '0;
    fack_d  = '0;
    rd_d    = '0;
    jump_d  = '0;
    mem_req = '0;
    cnt_inc = tc_q[CNT_W-1:0] + 14'h0001;
    // data level first; data waits only while data is in service, service while either level is
    data_go = data_req_line & ctrl_q[0] & ~higher_level_active & ~busy_q[0];
    serv_go = serv_req_line & ctrl_q[1] & ~higher_level_active & ~(|busy_q);
    xfer_elig = dev_xfer_req & active_q & ~pend_q &
                {{12{pm_q == 8'h00}}, {4{pr_q == 8'h00}}};
    fin_pick = pick_lowest(dev_finish & ~active_q & ~seen_q);
    ld_pick  = pick_lowest(pend_q);
    xf_pick  = pick_lowest(xfer_elig);
    case (state_q)
      S_IDLE: begin
        if (fin_pick[4]) begin
          ch_d = fin_pick[3:0];
          if (is_reg_ch(fin_pick[3:0])) begin
            state_d = S_FIN;
          end else begin
            fack_d[fin_pick[3:0]] = 1'b1;
            seen_d[fin_pick[3:0]] = 1'b1;
          end
        end else if (ld_pick[4]) begin
          ch_d    = ld_pick[3:0];
          init_d  = 1'b1;
          state_d = S_LD_TC;
        end else if (xf_pick[4]) begin
          ch_d   = xf_pick[3:0];
          init_d = 1'b0;
          if (is_reg_ch(xf_pick[3:0])) begin
            tc_d    = rtc_q[xf_pick[1:0]];
            ta_d    = rta_q[xf_pick[1:0]];
            state_d = S_XFER;
          end else begin
            state_d = S_LD_TC;
          end
        end else if (data_go) begin
          lvl_d   = 1'b0;
          qcnt_d  = 3'h0;
          state_d = S_QUPD;
        end else if (serv_go) begin
          lvl_d   = 1'b1;
          qcnt_d  = 3'h0;
          state_d = S_QUPD;
        end
      end
      S_LD_TC: begin
        mem_req = '{valid: 1'b1, we: 1'b0, addr: TC_BASE + {12'h000, ch_q}, wdata: 16'h0000};
        if (mem_ready) begin
          tc_d    = mem_rdata;
          state_d = S_LD_TA;
        end
      end
      S_LD_TA: begin
        mem_req = '{valid: 1'b1, we: 1'b0, addr: TA_BASE + {12'h000, ch_q}, wdata: 16'h0000};
        if (mem_ready) begin
          ta_d = mem_rdata;
          if (init_q) begin
            rtc_d[ch_q[1:0]] = tc_q;
            rta_d[ch_q[1:0]] = mem_rdata;
            pend_d[ch_q]     = 1'b0;
            state_d          = S_IDLE;
          end else begin
            state_d = S_XFER;
          end
        end
      end
      S_XFER: begin
        // input channels write the device word straight through to memory
        mem_req = '{valid: 1'b1, we: dir_q[ch_q], addr: ta_q, wdata: dev_rdata};
        if (mem_ready) begin
          if (!dir_q[ch_q]) begin
            wd_d = mem_rdata;
          end
          ack_d[ch_q] = 1'b1;
          ta_d = ta_q + 16'h0001;
          tc_d = {tc_q[15:CNT_W], cnt_inc};
          if (is_reg_ch(ch_q)) begin
            pr_d = REG_PACE_CYC;
          end else begin
            pm_d = MEM_PACE_CYC;
          end
          state_d = S_STORE;
          if (cnt_inc == '0) begin
            done_d[ch_q] = 1'b1;
            if (!tc_q[CHAIN_BIT]) begin
              state_d = S_CH_TC;
            end else begin
              active_d[ch_q] = 1'b0;
            end
          end
        end
      end
      S_CH_TC: begin
        mem_req = '{valid: 1'b1, we: 1'b0, addr: ta_q, wdata: 16'h0000};
        if (mem_ready) begin
          tc_d    = mem_rdata;
          state_d = S_CH_TA;
        end
      end
      S_CH_TA: begin
        mem_req = '{valid: 1'b1, we: 1'b0, addr: ta_q + 16'h0001, wdata: 16'h0000};
        if (mem_ready) begin
          ta_d    = mem_rdata;
          state_d = S_STORE;
        end
      end
      S_STORE: begin
        if (is_reg_ch(ch_q)) begin
          rtc_d[ch_q[1:0]] = tc_q;
          rta_d[ch_q[1:0]] = ta_q;
          state_d          = S_IDLE;
        end else begin
          mem_req = '{valid: 1'b1, we: 1'b1, addr: TC_BASE + {12'h000, ch_q}, wdata: tc_q};
          if (mem_ready) begin
            state_d = S_ST_TA;
          end
        end
      end
      S_ST_TA: begin
        mem_req = '{valid: 1'b1, we: 1'b1, addr: TA_BASE + {12'h000, ch_q}, wdata: ta_q};
        if (mem_ready) begin
          state_d = S_IDLE;
        end
      end
      S_FIN: begin
        // address goes home before the controller may raise its service request
        mem_req = '{valid: 1'b1, we: 1'b1, addr: TA_BASE + {12'h000, ch_q}, wdata: rta_q[ch_q[1:0]]};
        if (mem_ready) begin
          fack_d[ch_q] = 1'b1;
          seen_d[ch_q] = 1'b1;
          state_d      = S_IDLE;
        end
      end
      S_QUPD: begin
        qcnt_d = qcnt_q + 3'h1;
        if (qcnt_q == QUPD_CYC - 3'h1) begin
          src_d   = src_id;
          state_d = S_PC_SAVE;
        end
      end
      S_PC_SAVE: begin
        mem_req = '{valid: 1'b1, we: 1'b1, addr: lvl_q ? SERV_RET_LOC : DATA_RET_LOC,
                    wdata: program_counter};
        if (mem_ready) begin
          state_d = S_VEC_RD;
        end
      end
      S_VEC_RD: begin
        mem_req = '{valid: 1'b1, we: 1'b0, wdata: 16'h0000,
                    addr: (lvl_q ? SERV_ENTRY_BASE : DATA_ENTRY_BASE) + {10'h000, src_q}};
        if (mem_ready) begin
          jump_d        = '{valid: 1'b1, addr: mem_rdata};
          busy_d[lvl_q] = 1'b1;
          state_d       = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    // register port last; a same-cycle initiate of the completing channel still sees it active and is ignored
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   rd_d = {14'h0000, ctrl_q};
        REG_DIR:    rd_d = dir_q;
        REG_CHAN:   rd_d = active_q;
        REG_STATUS: rd_d = {8'h00, busy_q, src_q};
        default:    rd_d = 16'h0000;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: ctrl_d = reg_wdata[1:0];
        REG_DIR:  dir_d  = reg_wdata;
        REG_CHAN: begin
          // an active channel ignores a second initiate
          if (!active_q[reg_wdata[3:0]]) begin
            active_d[reg_wdata[3:0]] = 1'b1;
            pend_d[reg_wdata[3:0]]   = is_reg_ch(reg_wdata[3:0]);
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= S_IDLE;
      ctrl_q   <= CTRL_RST;
      dir_q    <= DIR_RST;
      active_q <= '0;
      pend_q   <= '0;
      seen_q   <= '0;
      rtc_q    <= '{default: 16'h0000};
      rta_q    <= '{default: 16'h0000};
      tc_q     <= '0;
      ta_q     <= '0;
      ch_q     <= '0;
      init_q   <= 1'b0;
      lvl_q    <= 1'b0;
      src_q    <= '0;
      busy_q   <= '0;
      qcnt_q   <= '0;
      pr_q     <= '0;
      pm_q     <= '0;
      wd_q     <= '0;
      ack_q    <= '0;
      done_q   <= '0;
      fack_q   <= '0;
      rd_q     <= '0;
      jump_q   <= '0;
    end else begin
      state_q  <= state_d;
      ctrl_q   <= ctrl_d;
      dir_q    <= dir_d;
      active_q <= active_d;
      pend_q   <= pend_d;
      seen_q   <= seen_d;
      rtc_q    <= rtc_d;
      rta_q    <= rta_d;
      tc_q     <= tc_d;
      ta_q     <= ta_d;
      ch_q     <= ch_d;
      init_q   <= init_d;
      lvl_q    <= lvl_d;
      src_q    <= src_d;
      busy_q   <= busy_d;
      qcnt_q   <= qcnt_d;
      pr_q     <= pr_d;
      pm_q     <= pm_d;
      wd_q     <= wd_d;
      ack_q    <= ack_d;
      done_q   <= done_d;
      fack_q   <= fack_d;
      rd_q     <= rd_d;
      jump_q   <= jump_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_qupd_cause;
    @(posedge mclk) disable iff (!rst_n)
    $rose(queue_update) |-> $past(!higher_level_active) && $past(data_req_line || serv_req_line);
  endproperty
  a_qupd_cause: assert property (p_qupd_cause) else $error("queue update without request");
  property p_data_first;
    @(posedge mclk) disable iff (!rst_n)
    ($rose(queue_update) && queue_is_serv) |-> !($past(data_req_line) && $past(ctrl_q[0]) && !$past(busy_q[0]));
  endproperty
  a_data_first: assert property (p_data_first) else $error("service level beat data level");
  property p_qupd_len;
    @(posedge mclk) disable iff (!rst_n)
    $rose(queue_update) |-> queue_update ##1 queue_update ##1 !queue_update;
  endproperty
  a_qupd_len: assert property (p_qupd_len) else $error("queue update length wrong");
  property p_ret_loc;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == S_PC_SAVE) |-> mem_req.we && mem_req.addr == (lvl_q ? 16'h003A : 16'h0038);
  endproperty
  a_ret_loc: assert property (p_ret_loc) else $error("counter saved at wrong place");
  property p_entry;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == S_VEC_RD && mem_ready) |-> mem_req.addr[15:6] == (lvl_q ? 10'h003 : 10'h002)
      ##1 jump.valid && busy_q[lvl_q];
  endproperty
  a_entry: assert property (p_entry) else $error("bad vector fetch");
  property p_word_step;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == S_XFER && mem_ready) |=> ta_q == $past(ta_q) + 16'h0001 && |dev_xfer_ack;
  endproperty
  a_word_step: assert property (p_word_step) else $error("address not stepped");
  property p_done_zero;
    @(posedge mclk) disable iff (!rst_n)
    |block_done |-> tc_q[CNT_W-1:0] == 14'h0000 || $past(!tc_q[CHAIN_BIT]);
  endproperty
  a_done_zero: assert property (p_done_zero) else $error("done before count zero");
  property p_chain;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == S_XFER && mem_ready && cnt_inc == '0 && !tc_q[CHAIN_BIT]) |=> state_q == S_CH_TC;
  endproperty
  a_chain: assert property (p_chain) else $error("chain fetch missed");
  property p_fin_wb;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == S_FIN && mem_ready) |-> mem_req.we && mem_req.addr == 16'h0070 + {12'h000, ch_q}
      ##1 finish_ack[$past(ch_q)];
  endproperty
  a_fin_wb: assert property (p_fin_wb) else $error("final address not written back");
  logic [15:0] xfer_elig_past;
  property p_lowest;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == S_IDLE && !fin_pick[4] && !ld_pick[4] && xf_pick[4]) |=>
      ((xfer_elig_past & ((16'h0001 << ch_q) - 16'h0001)) == 16'h0000);
  endproperty
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_elig_past <= '0;
    end else begin
      xfer_elig_past <= xfer_elig;
    end
  end
  a_lowest: assert property (p_lowest) else $error("higher channel served first");
endmodule // io_interrupt_queue_and_block_dma
`default_nettype wire

// ### src/io_irq_dma_pkg.sv
// constants, types and states for the i/o interrupt queue and block dma
package io_irq_dma_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned REG_RATE_WPS = 400_000;
  localparam int unsigned MEM_RATE_WPS = 200_000;
  // least spacing between words, rounded up
  localparam logic [7:0] REG_PACE_CYC = 8'((CLK_HZ + REG_RATE_WPS - 1) / REG_RATE_WPS);
  localparam logic [7:0] MEM_PACE_CYC = 8'((CLK_HZ + MEM_RATE_WPS - 1) / MEM_RATE_WPS);
  localparam logic [2:0] QUPD_CYC     = 3'h2;
  // ****************************************
  // dedicated memory locations
  // ****************************************
  localparam logic [15:0] DATA_RET_LOC    = 16'h0038;
  localparam logic [15:0] SERV_RET_LOC    = 16'h003A;
  localparam logic [15:0] DATA_ENTRY_BASE = 16'h0080;
  localparam logic [15:0] SERV_ENTRY_BASE = 16'h00C0;
  localparam logic [15:0] TC_BASE         = 16'h0060;
  localparam logic [15:0] TA_BASE         = 16'h0070;
  // ****************************************
  // count word layout and registers
  // ****************************************
  localparam int unsigned CHAIN_BIT = 15;
  localparam int unsigned CNT_W     = 14;
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_DIR    = 2'h1;
  localparam logic [1:0] REG_CHAN   = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [15:0] DIR_RST   = 16'h0000;
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } jump_t;
  typedef enum {S_IDLE, S_LD_TC, S_LD_TA, S_XFER, S_STORE, S_ST_TA, S_CH_TC, S_CH_TA,
                S_FIN, S_QUPD, S_PC_SAVE, S_VEC_RD} fsm_t;
endpackage

// ### verif/far_side_model.sv
// far-side model: party-line controllers on sub-levels and main memory
`timescale 1ns/100ps
`default_nettype none
module far_side_model
  import io_irq_dma_pkg::*;
#(
  parameter logic [5:0] ID_BASE = 6'h10
)
(
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire io_irq_dma_pkg::mem_req_t mem_req,
  output logic                          mem_ready,
  output logic [15:0]                   mem_rdata,
  input  wire logic                     queue_update,
  input  wire logic                     queue_is_serv,
  output logic                          data_req_line,
  output logic                          serv_req_line,
  output logic [5:0]                    src_id,
  input  wire logic [1:0]               conn,
  input  wire logic [2:0]               slow,
  input  wire logic [15:0]              dreq_set,
  input  wire logic [15:0]              sreq_set
);
  logic [15:0] mem [0:511];
  logic [15:0] dreq_q, sreq_q, junk_q, pend;
  logic [3:0]  win;
  logic [2:0]  wait_q;
  logic        upd_q;
  // ****************************************
  // party line
  // ****************************************
  // one flip-flop per sub-level, wire-or onto the shared lines
  assign data_req_line = |dreq_q;
  assign serv_req_line = |sreq_q;
  assign pend          = queue_is_serv ? sreq_q : dreq_q;
  // bit 0 outranks the rest; lower sub-levels withdraw their ids
  always_comb begin
    win = 4'hF;
    for (int i = 15; i >= 0; i--) begin
      if (pend[i]) win = 4'(i);
    end
  end
  // released lines toggle so a late sample cannot match by luck
  assign src_id    = queue_update ? ID_BASE + 6'(win) : junk_q[5:0];
  assign mem_ready = mem_req.valid && wait_q == slow;
  assign mem_rdata = mem_ready ? mem[mem_req.addr[8:0]] : junk_q;
  // request flops, wait states, winner clears at update end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dreq_q <= 16'h0000;
      sreq_q <= 16'h0000;
      junk_q <= 16'h5A5A;
      wait_q <= 3'h0;
      upd_q  <= 1'b0;
    end else begin
      junk_q <= ~junk_q;
      upd_q  <= queue_update;
      wait_q <= (mem_ready || !mem_req.valid) ? 3'h0 : wait_q + 3'h1;
      // a disconnected level drops what it holds and latches nothing new
      dreq_q <= conn[0] ? (dreq_q | dreq_set) : 16'h0000;
      sreq_q <= conn[1] ? (sreq_q | sreq_set) : 16'h0000;
      if (upd_q && !queue_update && !queue_is_serv) dreq_q[win] <= 1'b0;
      if (upd_q && !queue_update && queue_is_serv) sreq_q[win] <= 1'b0;
    end
  end
  // plain always so the bench may preload words directly
  always @(posedge mclk) begin
    if (mem_ready && mem_req.we) mem[mem_req.addr[8:0]] <= mem_req.wdata;
  end
endmodule // far_side_model
`default_nettype wire

// ### verif/io_interrupt_queue_and_block_dma_tb.sv
// self-checking bench for the interrupt queue and block dma
`timescale 1ns/100ps
`default_nettype none
module io_interrupt_queue_and_block_dma_tb;
  import io_irq_dma_pkg::*;
  localparam logic [5:0] IDB = 6'h10;
  logic        mclk, rst_n, reg_wr, reg_rd, higher_level_active, mem_ready;
  logic        data_req_line, serv_req_line, queue_update, queue_is_serv;
  logic [1:0]  reg_addr, level_exit, conn;
  logic [2:0]  slow;
  logic [5:0]  src_id;
  logic [15:0] reg_wdata, reg_rdata, program_counter, mem_rdata, dev_xfer_req, dev_rdata, d;
  logic [15:0] dev_wdata, dev_xfer_ack, block_done, dev_finish, finish_ack, dreq_set, sreq_set;
  jump_t       jump;
  mem_req_t    mem_req;
  logic [49:0] ev;
  int          miscompares, cmp_count, k;
  int          sub [3] = '{2, 5, 9};
  assign ev = {jump.valid, queue_update, finish_ack, block_done, dev_xfer_ack};
  always #10 mclk = ~mclk;
  io_interrupt_queue_and_block_dma io_interrupt_queue_and_block_dma_i (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_req_line(data_req_line),
    .serv_req_line(serv_req_line), .higher_level_active(higher_level_active), .src_id(src_id),
    .queue_update(queue_update), .queue_is_serv(queue_is_serv), .program_counter(program_counter),
    .level_exit(level_exit), .jump(jump), .mem_req(mem_req), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .dev_xfer_req(dev_xfer_req), .dev_rdata(dev_rdata), .dev_wdata(dev_wdata),
    .dev_xfer_ack(dev_xfer_ack), .block_done(block_done), .dev_finish(dev_finish),
    .finish_ack(finish_ack));
  far_side_model #(.ID_BASE(IDB)) far_side_model_i (
    .mclk(mclk), .rst_n(rst_n), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .queue_update(queue_update), .queue_is_serv(queue_is_serv), .data_req_line(data_req_line),
    .serv_req_line(serv_req_line), .src_id(src_id), .conn(conn), .slow(slow), .dreq_set(dreq_set),
    .sreq_set(sreq_set));
  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // bounded wait on one event bit; k keeps the cycles spent
  task automatic wait_ev(input int b);
    k = 0;
    do begin
      tick();
      k++;
    end while (ev[b] !== 1'b1 && k < 2000);
    if (ev[b] !== 1'b1) chk("event wait", 16'(b), 16'hFFFF);
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic finish_ch(input int ch);
    @(posedge mclk);
    dev_finish[ch] <= 1'b1;
    wait_ev(32 + ch);
    @(posedge mclk);
    dev_finish[ch] <= 1'b0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the whole run needs well under a tenth of this
  initial begin
    #400_000;
    miscompares++;
    end_sim();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, higher_level_active, reg_addr, level_exit, conn, slow, reg_wdata} = '0;
    {dev_xfer_req, dev_rdata, dev_finish, dreq_set, sreq_set} = '0;
    program_counter = 16'h1234;
    for (int i = 0; i < 512; i++) far_side_model_i.mem[i] = 16'hA000 + 16'(i);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a));
      chk("reg reset", d, 16'h0000);
    end
    // both levels requested while a higher level holds them off
    wr(REG_CTRL, 16'h0003);
    @(posedge mclk);
    higher_level_active <= 1'b1;
    // sub-level 0 asks while still disconnected, so it must never win
    dreq_set <= 16'h0001;
    @(posedge mclk);
    conn <= 2'b11;
    dreq_set <= 16'h0024;
    sreq_set <= 16'h0200;
    @(posedge mclk);
    dreq_set <= 16'h0000;
    sreq_set <= 16'h0000;
    d = 16'h0000;
    repeat (30) begin
      tick();
      d[0] = d[0] | queue_update;
    end
    chk("update while blocked", d, 16'h0000);
    @(posedge mclk);
    higher_level_active <= 1'b0;
    wait_ev(48);
    d = 16'h0000;
    while (queue_update === 1'b1 && d < 16'h0008) begin
      d++;
      tick();
    end
    chk("update length", d, 16'(QUPD_CYC));
    // data sub-levels 2 then 5, service only after both
    for (int n = 0; n < 3; n++) begin
      wait_ev(49);
      chk("jump entry", jump.addr,
          16'hA000 + (n < 2 ? DATA_ENTRY_BASE : SERV_ENTRY_BASE) + 16'(IDB) + 16'(sub[n]));
      chk("pc saved", far_side_model_i.mem[n < 2 ? DATA_RET_LOC[8:0] : SERV_RET_LOC[8:0]], program_counter);
      chk("level served", 16'(queue_is_serv), 16'(n == 2));
      if (n == 0) rd(REG_STATUS);
      if (n == 0) chk("status", d, {8'h00, 2'b01, IDB + 6'h02});
      @(posedge mclk);
      level_exit <= n < 2 ? 2'b01 : 2'b10;
      program_counter <= program_counter + 16'h0111;
      @(posedge mclk);
      level_exit <= 2'b00;
    end
    // memory channel 5, output of two words, slow memory
    far_side_model_i.mem['h65] = 16'hBFFE;
    far_side_model_i.mem['h75] = 16'h0100;
    slow <= 3'h2;
    wr(REG_DIR, 16'h0002);
    wr(REG_CHAN, 16'h0005);
    rd(REG_CHAN);
    chk("active mask", d, 16'h0020);
    @(posedge mclk);
    dev_xfer_req <= 16'h0020;
    for (int w = 0; w < 2; w++) begin
      wait_ev(5);
      if (w == 1) chk("word pace", 16'(k >= 245), 16'h0001);
      chk("out word", dev_wdata, 16'hA100 + 16'(w));
      chk("block done", 16'(block_done[5]), 16'(w));
    end
    @(posedge mclk);
    dev_xfer_req <= 16'h0000;
    repeat (12) tick();
    chk("count word", far_side_model_i.mem['h65], 16'h8000);
    chk("address word", far_side_model_i.mem['h75], 16'h0102);
    rd(REG_CHAN);
    chk("mask after block", d, 16'h0000);
    finish_ch(5);
    // register channel 1, input, one chained block
    far_side_model_i.mem['h61] = 16'h3FFF;
    far_side_model_i.mem['h71] = 16'h0110;
    far_side_model_i.mem['h111] = 16'hBFFF;
    far_side_model_i.mem['h112] = 16'h0120;
    slow <= 3'h0;
    rd(REG_STATUS);
    chk("status before initiate", d, {8'h00, 2'b00, IDB + 6'h09});
    wr(REG_CHAN, 16'h0001);
    repeat (6) tick();
    far_side_model_i.mem['h71] = 16'h0000;
    @(posedge mclk);
    dev_rdata <= 16'h5A01;
    dev_xfer_req <= 16'h0002;
    for (int w = 0; w < 2; w++) begin
      wait_ev(1);
      chk("chain done", 16'(block_done[1]), 16'h0001);
      @(posedge mclk);
      dev_rdata <= 16'h5A02;
      // a reload here would send the second block to the cleared address
      if (w == 0) wr(REG_CHAN, 16'h0001);
    end
    dev_xfer_req <= 16'h0000;
    repeat (4) tick();
    chk("chain word 1", far_side_model_i.mem['h110], 16'h5A01);
    chk("chain word 2", far_side_model_i.mem['h120], 16'h5A02);
    finish_ch(1);
    chk("final address", far_side_model_i.mem['h71], 16'h0121);
    end_sim();
  end
endmodule // io_interrupt_queue_and_block_dma_tb
`default_nettype wire
